// >>> hw/regmap_pkg.sv
// Purpose: constants for the data-memory register file
// Assumes: 8-bit data, 8-bit file address (bank bit + 7-bit field)
// Notes: offsets are full file addresses
package regmap_pkg;
  localparam logic [7:0] ADDR_INDIRECT_DATA = 8'h00;
  localparam logic [7:0] ADDR_TIMER_ZERO_COUNT = 8'h01;
  localparam logic [7:0] ADDR_PC_LOW = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_POINTER = 8'h04;
  localparam logic [7:0] ADDR_PORT_A = 8'h05;
  localparam logic [7:0] ADDR_PORT_B = 8'h06;
  localparam logic [7:0] ADDR_PC_HIGH_LATCH = 8'h0a;
  localparam logic [7:0] ADDR_INT_CONTROL = 8'h0b;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_TMR1_LOW = 8'h0e;
  localparam logic [7:0] ADDR_TMR1_HIGH = 8'h0f;
  localparam logic [7:0] ADDR_TMR1_CTRL = 8'h10;
  localparam logic [7:0] ADDR_TIMER_TWO_COUNT = 8'h11;
  localparam logic [7:0] ADDR_TIMER_TWO_COUNT_CTRL = 8'h12;
  localparam logic [7:0] ADDR_CCP_LOW = 8'h15;
  localparam logic [7:0] ADDR_CCP_HIGH = 8'h16;
  localparam logic [7:0] ADDR_CCP_CTRL = 8'h17;
  localparam logic [7:0] ADDR_PWM_CTRL = 8'h18;
  localparam logic [7:0] ADDR_SHUTDOWN = 8'h19;
  localparam logic [7:0] ADDR_CONV_RESULT = 8'h1e;
  localparam logic [7:0] ADDR_CONV_MAIN = 8'h1f;
  localparam logic [7:0] ADDR_OPTION = 8'h81;
  localparam logic [7:0] ADDR_PORT_A_DIR = 8'h85;
  localparam logic [7:0] ADDR_PORT_B_DIR = 8'h86;
  localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h8e;
  localparam logic [7:0] ADDR_TIMER_TWO_COUNT_PERIOD = 8'h92;
  localparam logic [7:0] ADDR_CONV_PINS = 8'h9f;
  localparam logic [7:0] MIRROR_BIT = 8'h80;
  localparam logic [6:0] GPR_BASE = 7'h20;
  localparam logic [6:0] GPR_SHARED_BASE = 7'h70;
  localparam logic [6:0] GPR_B1_TOP = 7'h3f;
  localparam int GPR_DEPTH = 128;
  // implemented-bit masks and status writable-bit mask
  localparam logic [7:0] MASK_STATUS = 8'h3f;
  localparam logic [7:0] MASK_STATUS_WR = 8'h27;
  localparam logic [7:0] MASK_PORT_A = 8'h1f;
  localparam logic [7:0] MASK_PC_HIGH = 8'h1f;
  localparam logic [7:0] MASK_IRQ = 8'h47;
  localparam logic [7:0] MASK_TMR1_CTRL = 8'h3f;
  localparam logic [7:0] MASK_TIMER_TWO_COUNT_CTRL = 8'h7f;
  localparam logic [7:0] MASK_SHUTDOWN = 8'hdf;
  localparam logic [7:0] MASK_CONV_MAIN = 8'hfd;
  localparam logic [7:0] MASK_RESET_CAUSE = 8'h03;
  localparam logic [7:0] MASK_CONV_PINS = 8'h07;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_ONES = 8'hff;
  localparam logic [7:0] RST_PORT_A_DIR = 8'h1f;
  localparam logic [7:0] RST_RESET_CAUSE = 8'h00;
  localparam int BANK_BIT = 5;
endpackage : regmap_pkg

// >>> hw/data_memory_register_map.sv
// Purpose: data-memory register file with two banks, mirrors and indirect access
// Assumes: core presents one access per cycle; reads are combinational
// Notes: peripheral behaviour lives elsewhere; conversion result and port pin levels come in as inputs
`timescale 1ns/100ps
module data_memory_register_map #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // core access
  input wire logic [6:0] instr_addr,
  input wire logic use_indirect,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data,
  // program counter
  input wire logic pc_load,
  input wire logic [7:0] pc_load_low,
  output logic [12:0] pc_value,
  // alu flags from core
  input wire logic flags_we,
  input wire logic [2:0] flags_in,
  // peripheral inputs
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] conv_result_in,
  // port outputs and status bank bit
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_dir,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_dir,
  output logic bank_select_low
);
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] pointer;
    logic [7:0] pc_low;
    logic [4:0] pc_high;
    logic [7:0] pc_high_latch;
    logic [7:0] int_ctrl;
    logic [7:0] pa_latch;
    logic [7:0] pb_latch;
    logic [7:0] pa_dir;
    logic [7:0] pb_dir;
    logic [7:0] timer_zero_count;
    logic [7:0] irq_flags;
    logic [7:0] timer_one_low_byte;
    logic [7:0] timer_one_high_byte;
    logic [7:0] tmr1c;
    logic [7:0] timer_two_count;
    logic [7:0] tmr2c;
    logic [7:0] ccpl;
    logic [7:0] ccph;
    logic [7:0] ccpc;
    logic [7:0] pwmc;
    logic [7:0] shutdown;
    logic [7:0] conv_main;
    logic [7:0] option;
    logic [7:0] irq_en;
    logic [7:0] reset_cause;
    logic [7:0] tmr2p;
    logic [7:0] conv_pins;
  } regs_s;

  regs_s state_reg;
  regs_s state_next;
  logic [7:0] gpr_mem [regmap_pkg::GPR_DEPTH];
  logic [7:0] eff_addr;
  logic [7:0] cmp_addr;
  logic gpr_hit;
  logic [6:0] gpr_index;
  logic [7:0] rd_value;

  // effective address: pointer or bank bit over instruction field
  always_comb begin
    if (use_indirect) begin
      eff_addr = state_reg.pointer;
    end else begin
      eff_addr = {state_reg.status[regmap_pkg::BANK_BIT], instr_addr};
    end
  end

  // mirrored core registers fold onto bank 0 decode
  always_comb begin
    cmp_addr = eff_addr;
    if (eff_addr[7] && (eff_addr[6:0] == regmap_pkg::ADDR_INDIRECT_DATA[6:0]
        || eff_addr[6:0] == regmap_pkg::ADDR_PC_LOW[6:0]
        || eff_addr[6:0] == regmap_pkg::ADDR_STATUS[6:0]
        || eff_addr[6:0] == regmap_pkg::ADDR_POINTER[6:0]
        || eff_addr[6:0] == regmap_pkg::ADDR_PC_HIGH_LATCH[6:0]
        || eff_addr[6:0] == regmap_pkg::ADDR_INT_CONTROL[6:0])) begin
      cmp_addr = eff_addr & ~regmap_pkg::MIRROR_BIT;
    end
  end

  // general storage decode: shared top 16 bytes, bank 1 A0h-BFh only
  always_comb begin
    gpr_hit = 1'b0;
    gpr_index = eff_addr[6:0];
    if (eff_addr[6:0] >= regmap_pkg::GPR_SHARED_BASE) begin
      gpr_hit = 1'b1;
    end else if (!eff_addr[7] && eff_addr[6:0] >= regmap_pkg::GPR_BASE) begin
      gpr_hit = 1'b1;
    end else if (eff_addr[7] && eff_addr[6:0] >= regmap_pkg::GPR_BASE
        && eff_addr[6:0] <= regmap_pkg::GPR_B1_TOP) begin
      gpr_hit = 1'b1;
      // cells 00h-1Fh are free; 20h-3Fh would alias bank 0 storage
      gpr_index = eff_addr[6:0] - regmap_pkg::GPR_BASE;
    end
  end

  // read mux; anything undecoded returns zero
  always_comb begin
    rd_value = 8'h00;
    if (gpr_hit) begin
      rd_value = gpr_mem[gpr_index];
    end else if (cmp_addr == regmap_pkg::ADDR_PC_LOW) begin
      rd_value = state_reg.pc_low;
    end else if (cmp_addr == regmap_pkg::ADDR_STATUS) begin
      rd_value = state_reg.status & regmap_pkg::MASK_STATUS;
    end else if (cmp_addr == regmap_pkg::ADDR_POINTER) begin
      rd_value = state_reg.pointer;
    end else if (cmp_addr == regmap_pkg::ADDR_PC_HIGH_LATCH) begin
      rd_value = state_reg.pc_high_latch & regmap_pkg::MASK_PC_HIGH;
    end else if (cmp_addr == regmap_pkg::ADDR_INT_CONTROL) begin
      rd_value = state_reg.int_ctrl;
    end else if (cmp_addr == regmap_pkg::ADDR_TIMER_ZERO_COUNT) begin
      rd_value = state_reg.timer_zero_count;
    end else if (cmp_addr == regmap_pkg::ADDR_PORT_A) begin
      rd_value = port_a_pins & regmap_pkg::MASK_PORT_A;
    end else if (cmp_addr == regmap_pkg::ADDR_PORT_B) begin
      rd_value = port_b_pins;
    end else if (cmp_addr == regmap_pkg::ADDR_IRQ_FLAGS) begin
      rd_value = state_reg.irq_flags & regmap_pkg::MASK_IRQ;
    end else if (cmp_addr == regmap_pkg::ADDR_TMR1_LOW) begin
      rd_value = state_reg.timer_one_low_byte;
    end else if (cmp_addr == regmap_pkg::ADDR_TMR1_HIGH) begin
      rd_value = state_reg.timer_one_high_byte;
    end else if (cmp_addr == regmap_pkg::ADDR_TMR1_CTRL) begin
      rd_value = state_reg.tmr1c & regmap_pkg::MASK_TMR1_CTRL;
    end else if (cmp_addr == regmap_pkg::ADDR_TIMER_TWO_COUNT) begin
      rd_value = state_reg.timer_two_count;
    end else if (cmp_addr == regmap_pkg::ADDR_TIMER_TWO_COUNT_CTRL) begin
      rd_value = state_reg.tmr2c & regmap_pkg::MASK_TIMER_TWO_COUNT_CTRL;
    end else if (cmp_addr == regmap_pkg::ADDR_CCP_LOW) begin
      rd_value = state_reg.ccpl;
    end else if (cmp_addr == regmap_pkg::ADDR_CCP_HIGH) begin
      rd_value = state_reg.ccph;
    end else if (cmp_addr == regmap_pkg::ADDR_CCP_CTRL) begin
      rd_value = state_reg.ccpc;
    end else if (cmp_addr == regmap_pkg::ADDR_PWM_CTRL) begin
      rd_value = state_reg.pwmc;
    end else if (cmp_addr == regmap_pkg::ADDR_SHUTDOWN) begin
      rd_value = state_reg.shutdown & regmap_pkg::MASK_SHUTDOWN;
    end else if (cmp_addr == regmap_pkg::ADDR_CONV_RESULT) begin
      rd_value = conv_result_in;
    end else if (cmp_addr == regmap_pkg::ADDR_CONV_MAIN) begin
      rd_value = state_reg.conv_main & regmap_pkg::MASK_CONV_MAIN;
    end else if (cmp_addr == regmap_pkg::ADDR_OPTION) begin
      rd_value = state_reg.option;
    end else if (cmp_addr == regmap_pkg::ADDR_PORT_A_DIR) begin
      rd_value = state_reg.pa_dir & regmap_pkg::MASK_PORT_A;
    end else if (cmp_addr == regmap_pkg::ADDR_PORT_B_DIR) begin
      rd_value = state_reg.pb_dir;
    end else if (cmp_addr == regmap_pkg::ADDR_IRQ_ENABLES) begin
      rd_value = state_reg.irq_en & regmap_pkg::MASK_IRQ;
    end else if (cmp_addr == regmap_pkg::ADDR_RESET_CAUSE) begin
      rd_value = state_reg.reset_cause & regmap_pkg::MASK_RESET_CAUSE;
    end else if (cmp_addr == regmap_pkg::ADDR_TIMER_TWO_COUNT_PERIOD) begin
      rd_value = state_reg.tmr2p;
    end else if (cmp_addr == regmap_pkg::ADDR_CONV_PINS) begin
      rd_value = state_reg.conv_pins & regmap_pkg::MASK_CONV_PINS;
    end
  end

  // next-state: writes, flag updates, pc load, reset values
  always_comb begin
    state_next = state_reg;
    if (flags_we) begin
      state_next.status[2:0] = flags_in;
    end
    if (wr_en && !gpr_hit) begin
      if (cmp_addr == regmap_pkg::ADDR_PC_LOW) begin
        state_next.pc_low = wr_data;
        state_next.pc_high = state_reg.pc_high_latch[4:0];
      end else if (cmp_addr == regmap_pkg::ADDR_STATUS) begin
        // time-out and power-down bits are read only
        state_next.status = (state_reg.status & ~regmap_pkg::MASK_STATUS_WR)
          | (wr_data & regmap_pkg::MASK_STATUS_WR);
        if (flags_we) begin
          state_next.status[2:0] = flags_in;
        end
      end else if (cmp_addr == regmap_pkg::ADDR_POINTER) begin
        state_next.pointer = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_PC_HIGH_LATCH) begin
        state_next.pc_high_latch = wr_data & regmap_pkg::MASK_PC_HIGH;
      end else if (cmp_addr == regmap_pkg::ADDR_INT_CONTROL) begin
        state_next.int_ctrl = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_TIMER_ZERO_COUNT) begin
        state_next.timer_zero_count = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_PORT_A) begin
        state_next.pa_latch = wr_data & regmap_pkg::MASK_PORT_A;
      end else if (cmp_addr == regmap_pkg::ADDR_PORT_B) begin
        state_next.pb_latch = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_IRQ_FLAGS) begin
        state_next.irq_flags = wr_data & regmap_pkg::MASK_IRQ;
      end else if (cmp_addr == regmap_pkg::ADDR_TMR1_LOW) begin
        state_next.timer_one_low_byte = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_TMR1_HIGH) begin
        state_next.timer_one_high_byte = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_TMR1_CTRL) begin
        state_next.tmr1c = wr_data & regmap_pkg::MASK_TMR1_CTRL;
      end else if (cmp_addr == regmap_pkg::ADDR_TIMER_TWO_COUNT) begin
        state_next.timer_two_count = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_TIMER_TWO_COUNT_CTRL) begin
        state_next.tmr2c = wr_data & regmap_pkg::MASK_TIMER_TWO_COUNT_CTRL;
      end else if (cmp_addr == regmap_pkg::ADDR_CCP_LOW) begin
        state_next.ccpl = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_CCP_HIGH) begin
        state_next.ccph = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_CCP_CTRL) begin
        state_next.ccpc = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_PWM_CTRL) begin
        state_next.pwmc = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_SHUTDOWN) begin
        state_next.shutdown = wr_data & regmap_pkg::MASK_SHUTDOWN;
      end else if (cmp_addr == regmap_pkg::ADDR_CONV_MAIN) begin
        state_next.conv_main = wr_data & regmap_pkg::MASK_CONV_MAIN;
      end else if (cmp_addr == regmap_pkg::ADDR_OPTION) begin
        state_next.option = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_PORT_A_DIR) begin
        state_next.pa_dir = wr_data & regmap_pkg::MASK_PORT_A;
      end else if (cmp_addr == regmap_pkg::ADDR_PORT_B_DIR) begin
        state_next.pb_dir = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_IRQ_ENABLES) begin
        state_next.irq_en = wr_data & regmap_pkg::MASK_IRQ;
      end else if (cmp_addr == regmap_pkg::ADDR_RESET_CAUSE) begin
        state_next.reset_cause = wr_data & regmap_pkg::MASK_RESET_CAUSE;
      end else if (cmp_addr == regmap_pkg::ADDR_TIMER_TWO_COUNT_PERIOD) begin
        state_next.tmr2p = wr_data;
      end else if (cmp_addr == regmap_pkg::ADDR_CONV_PINS) begin
        state_next.conv_pins = wr_data & regmap_pkg::MASK_CONV_PINS;
      end
    end
    // core jump/branch loads the full pc
    if (pc_load) begin
      state_next.pc_low = pc_load_low;
      state_next.pc_high = state_reg.pc_high_latch[4:0];
    end
    if (srst) begin
      state_next = '0;
      state_next.status = regmap_pkg::RST_STATUS;
      state_next.pa_dir = regmap_pkg::RST_PORT_A_DIR;
      state_next.pb_dir = regmap_pkg::RST_ONES;
      state_next.option = regmap_pkg::RST_ONES;
      state_next.tmr2p = regmap_pkg::RST_ONES;
      state_next.pa_latch = regmap_pkg::RST_ZERO;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    state_reg <= state_next;
  end

  // general storage cells, uninitialised like static ram
  always_ff @(posedge clock) begin
    if (wr_en && gpr_hit && !srst) begin
      gpr_mem[gpr_index] <= wr_data;
    end
  end

  // outputs
  assign rd_data = rd_en ? rd_value : 8'h00;
  assign pc_value = {state_reg.pc_high, state_reg.pc_low};
  assign port_a_out = state_reg.pa_latch;
  assign port_a_dir = state_reg.pa_dir;
  assign port_b_out = state_reg.pb_latch;
  assign port_b_dir = state_reg.pb_dir;
  assign bank_select_low = state_reg.status[regmap_pkg::BANK_BIT];

  // checks
  property p_dir_reset;
    @(posedge clock) srst |=> (port_a_dir == 8'h1f && port_b_dir == 8'hff);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("ports not inputs after reset");
  property p_status_reset;
    @(posedge clock) srst |=> (state_reg.status[7:3] == 5'b00011);
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status reset wrong");
  property p_pa_latch_reset;
    @(posedge clock) srst |=> (port_a_out[3:0] == 4'h0);
  endproperty
  a_pa_latch_reset: assert property (p_pa_latch_reset) else $error("port a latch reset");
  property p_indirect;
    @(posedge clock) disable iff (srst) use_indirect |-> eff_addr == state_reg.pointer;
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect address wrong");
  property p_direct;
    @(posedge clock) disable iff (srst)
      !use_indirect |-> eff_addr == {bank_select_low, instr_addr};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_unimpl_zero;
    @(posedge clock) disable iff (srst)
      (rd_en && !gpr_hit && eff_addr[6:0] >= 7'h07 && eff_addr[6:0] <= 7'h09) |-> rd_data == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read nonzero");
  property p_pc_load;
    @(posedge clock) disable iff (srst)
      pc_load |=> pc_value[12:8] == $past(state_reg.pc_high_latch[4:0]);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc high not from latch");
  property p_shutdown_bit5;
    @(posedge clock) disable iff (srst)
      (rd_en && cmp_addr == 8'h19 && !gpr_hit) |-> rd_data[5] == 1'b0;
  endproperty
  a_shutdown_bit5: assert property (p_shutdown_bit5) else $error("shutdown bit 5 set");
  property p_b1_hole;
    @(posedge clock) disable iff (srst)
      (rd_en && eff_addr >= 8'hc0 && eff_addr <= 8'hef) |-> rd_data == 8'h00;
  endproperty
  a_b1_hole: assert property (p_b1_hole) else $error("bank 1 hole nonzero");
  property p_mirror;
    @(posedge clock) disable iff (srst)
      (rd_en && eff_addr == 8'h83) |-> rd_data == {2'b00, state_reg.status[5:0]};
  endproperty
  a_mirror: assert property (p_mirror) else $error("status mirror broken");
endmodule : data_memory_register_map

// >>> verif/core_model.sv
// Purpose: processor core stand-in issuing register file accesses
// Assumes: one access per cycle, inputs change 1 ns after the rising edge
// Notes: reads sampled combinationally inside the cycle of the request
`timescale 1ns/100ps
module core_model (
  // clock
  input wire logic clock,
  // access to the register file
  output logic [6:0] instr_addr,
  output logic use_indirect,
  output logic rd_en,
  output logic wr_en,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  // program counter and flags
  output logic pc_load,
  output logic [7:0] pc_load_low,
  output logic flags_we,
  output logic [2:0] flags_in
);
  // idle values from time zero
  initial begin
    instr_addr = 7'h00;
    use_indirect = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wr_data = 8'h00;
    pc_load = 1'b0;
    pc_load_low = 8'h00;
    flags_we = 1'b0;
    flags_in = 3'h0;
  end

  // one access: strobes stand from just after one edge through the next
  task automatic acc(input logic [6:0] a, input logic ind, input logic r, input logic w,
      input logic [7:0] d, output logic [7:0] v);
    @(posedge clock);
    #1;
    instr_addr = a;
    use_indirect = ind;
    wr_data = d;
    rd_en = r;
    wr_en = w;
    #1;
    v = rd_data;
    @(posedge clock);
    #1;
    rd_en = 1'b0;
    wr_en = 1'b0;
    use_indirect = 1'b0;
    wr_data = ~d;
  endtask : acc

  // one write, taken at the next rising edge
  task automatic wr(input logic [6:0] a, input logic ind, input logic [7:0] d);
    logic [7:0] dummy_v;
    acc(a, ind, 1'b0, 1'b1, d, dummy_v);
  endtask : wr

  // one read, data taken inside the cycle of the request
  task automatic rd(input logic [6:0] a, input logic ind, output logic [7:0] v);
    acc(a, ind, 1'b1, 1'b0, 8'h00, v);
  endtask : rd

  // bank pick through status, upper reserved bits kept clear
  task automatic bank(input logic b);
    wr(7'h03, 1'b0, {2'b00, b, 5'h00});
  endtask : bank

  // core strobes for pc load and alu flag update, one cycle each
  task automatic side(input logic ld, input logic fl, input logic [7:0] low,
      input logic [2:0] f);
    @(posedge clock);
    #1;
    pc_load_low = low;
    flags_in = f;
    pc_load = ld;
    flags_we = fl;
    @(posedge clock);
    #1;
    pc_load = 1'b0;
    flags_we = 1'b0;
  endtask : side

  // program counter load from the core
  task automatic pcload(input logic [7:0] low);
    side(1'b1, 1'b0, low, 3'h0);
  endtask : pcload

  // alu flag update from the core
  task automatic flags(input logic [2:0] f);
    side(1'b0, 1'b1, 8'h00, f);
  endtask : flags
endmodule : core_model

// >>> verif/tb.sv
// Purpose: self-checking bench for the data-memory register file
// Assumes: 200 MHz clock, synchronous active-high reset
// Notes: table rows write then read back one location each
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic bnk;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] expv;
  } row_s;
  logic clock, srst, use_indirect, rd_en, wr_en, pc_load, flags_we, bank_select_low;
  logic [6:0] instr_addr;
  logic [7:0] wr_data, rd_data, pc_load_low, port_a_pins, port_b_pins, conv_result_in;
  logic [7:0] port_a_out, port_a_dir, port_b_out, port_b_dir, v;
  logic [2:0] flags_in;
  logic [12:0] pc_value;
  int bad_count = 0;
  int samples_checked = 0;
  row_s rows [17] = '{
    '{1'b0, 7'h20, 8'h5a, 8'h5a}, '{1'b1, 7'h20, 8'h77, 8'h77}, '{1'b1, 7'h40, 8'hff, 8'h00},
    '{1'b1, 7'h6f, 8'hff, 8'h00}, '{1'b0, 7'h0a, 8'hff, 8'h1f}, '{1'b1, 7'h0a, 8'h13, 8'h13},
    '{1'b0, 7'h19, 8'hff, 8'hdf}, '{1'b0, 7'h08, 8'hff, 8'h00}, '{1'b0, 7'h14, 8'hff, 8'h00},
    '{1'b0, 7'h1c, 8'hff, 8'h00}, '{1'b1, 7'h1f, 8'hff, 8'h07}, '{1'b0, 7'h1f, 8'hfd, 8'hfd},
    '{1'b0, 7'h10, 8'hff, 8'h3f}, '{1'b1, 7'h0e, 8'hff, 8'h03}, '{1'b1, 7'h11, 8'hff, 8'h00},
    '{1'b0, 7'h0c, 8'hff, 8'h47}, '{1'b0, 7'h1e, 8'hff, 8'h6b}};

  // design under test
  data_memory_register_map dut_u (.clock(clock), .srst(srst), .instr_addr(instr_addr),
    .use_indirect(use_indirect), .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data),
    .rd_data(rd_data), .pc_load(pc_load), .pc_load_low(pc_load_low), .pc_value(pc_value),
    .flags_we(flags_we), .flags_in(flags_in), .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins), .conv_result_in(conv_result_in), .port_a_out(port_a_out),
    .port_a_dir(port_a_dir), .port_b_out(port_b_out), .port_b_dir(port_b_dir),
    .bank_select_low(bank_select_low));

  // core side
  core_model core_u (.clock(clock), .instr_addr(instr_addr), .use_indirect(use_indirect),
    .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .pc_load(pc_load),
    .pc_load_low(pc_load_low), .flags_we(flags_we), .flags_in(flags_in));

  // compare one value
  task automatic check(input logic [12:0] seen, input logic [12:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, expv);
    end
  endtask : check

  // verdict and end of run
  task automatic close_out();
    $display("compared %0d values, %0d mismatches", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    close_out();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    port_a_pins = 8'h00;
    port_b_pins = 8'h3c;
    conv_result_in = 8'h6b;
    repeat (2) @(posedge clock);
    #1;
    srst = 1'b0;
    for (int i = 0; i < 17; i++) begin
      core_u.bank(rows[i].bnk);
      core_u.wr(rows[i].addr, 1'b0, rows[i].wdata);
      core_u.rd(rows[i].addr, 1'b0, v);
      check({5'h00, v}, {5'h00, rows[i].expv});
    end
    $display("table test done");
    // mirrors and pointer access
    core_u.bank(1'b0);
    core_u.wr(7'h0b, 1'b0, 8'h81);
    core_u.bank(1'b1);
    core_u.rd(7'h0b, 1'b0, v);
    check({5'h00, v}, 13'h0081);
    core_u.wr(7'h04, 1'b0, 8'ha5);
    core_u.bank(1'b0);
    core_u.rd(7'h04, 1'b0, v);
    check({5'h00, v}, 13'h00a5);
    core_u.wr(7'h45, 1'b0, 8'h11);
    core_u.wr(7'h00, 1'b1, 8'h3e);
    core_u.wr(7'h70, 1'b0, 8'h9c);
    core_u.rd(7'h45, 1'b0, v);
    check({5'h00, v}, 13'h0011);
    core_u.bank(1'b1);
    core_u.rd(7'h25, 1'b0, v);
    check({5'h00, v}, 13'h003e);
    core_u.rd(7'h70, 1'b0, v);
    check({5'h00, v}, 13'h009c);
    core_u.rd(7'h00, 1'b1, v);
    check({5'h00, v}, 13'h003e);
    $display("mirror test done");
    // status bank bit and flags
    check({12'h000, bank_select_low}, 13'h0001);
    core_u.rd(7'h03, 1'b0, v);
    check({5'h00, v}, 13'h0038);
    core_u.flags(3'h5);
    core_u.rd(7'h03, 1'b0, v);
    check({5'h00, v}, 13'h003d);
    // status write and flag update in one cycle: flags win
    fork
      core_u.wr(7'h03, 1'b0, 8'h27);
      core_u.flags(3'h2);
    join
    core_u.rd(7'h03, 1'b0, v);
    check({5'h00, v}, 13'h003a);
    $display("status test done");
    // program counter high latch
    core_u.bank(1'b0);
    core_u.wr(7'h0a, 1'b0, 8'h15);
    core_u.pcload(8'h42);
    check(pc_value, 13'h1542);
    core_u.wr(7'h02, 1'b0, 8'h10);
    check(pc_value, 13'h1510);
    core_u.bank(1'b1);
    core_u.wr(7'h02, 1'b0, 8'h20);
    check(pc_value, 13'h1520);
    // pc load and pc low write in one cycle: the load wins
    fork
      core_u.wr(7'h02, 1'b0, 8'h77);
      core_u.pcload(8'h42);
    join
    check(pc_value, 13'h1542);
    $display("pc test done");
    // port latch versus pins
    core_u.bank(1'b0);
    port_a_pins = 8'hea;
    core_u.wr(7'h05, 1'b0, 8'h0f);
    check({5'h00, port_a_out}, 13'h000f);
    core_u.rd(7'h05, 1'b0, v);
    check({5'h00, v}, 13'h000a);
    port_b_pins = 8'h96;
    core_u.wr(7'h06, 1'b0, 8'hc3);
    check({5'h00, port_b_out}, 13'h00c3);
    core_u.rd(7'h06, 1'b0, v);
    check({5'h00, v}, 13'h0096);
    conv_result_in = 8'h94;
    core_u.rd(7'h1e, 1'b0, v);
    check({5'h00, v}, 13'h0094);
    $display("port test done");
    // reset in mid-run
    core_u.bank(1'b1);
    core_u.wr(7'h06, 1'b0, 8'h00);
    check({5'h00, port_b_dir}, 13'h0000);
    @(posedge clock);
    #1;
    srst = 1'b1;
    @(posedge clock);
    #1;
    srst = 1'b0;
    check({5'h00, port_b_dir}, 13'h00ff);
    check({5'h00, port_a_dir}, 13'h001f);
    check({5'h00, port_a_out}, 13'h0000);
    check({5'h00, port_b_out}, 13'h0000);
    check(pc_value, 13'h0000);
    check({12'h000, bank_select_low}, 13'h0000);
    core_u.rd(7'h03, 1'b0, v);
    check({5'h00, v}, 13'h0018);
    core_u.rd(7'h0b, 1'b0, v);
    check({5'h00, v}, 13'h0000);
    core_u.rd(7'h0a, 1'b0, v);
    check({5'h00, v}, 13'h0000);
    core_u.bank(1'b1);
    core_u.rd(7'h01, 1'b0, v);
    check({5'h00, v}, 13'h00ff);
    core_u.rd(7'h70, 1'b0, v);
    check({5'h00, v}, 13'h009c);
    $display("reset test done");
    close_out();
  end
endmodule : tb
